// File: cks_sequencer.sv
// kick sensor converter: mode sequence, two-wire slave, conversions and result registers
`timescale 1ns/1ps
`include "cks_cfg.svh"
module cks_sequencer
  import cks_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // host control pins
  input  wire logic        shutdown,
  input  wire logic        addr_sel,
  // two-wire bus
  input  wire cks_pins_s   bus_in,
  output logic             sda_out_ff,
  output logic             sda_oe_ff,
  // sensor frequency counts per channel
  input  wire logic [27:0] chan0_count,
  input  wire logic [27:0] chan1_count,
  // outputs to host and board
  output logic             result_ready_irq_n,
  output logic             osc_enable_ff,
  output logic [1:0]       mode_ff
);
  ////////////////////////////////////////////////////////////////////////////
  cks_mode_e   mode_q, nxt_mode;
  cks_bus_e    bus_ff, nxt_bus;
  logic [1:0]  pins_d_ff, nxt_pins_d;
  logic [3:0]  bit_ff, nxt_bit;
  logic [7:0]  shift_ff, nxt_shift;
  logic [7:0]  ptr_ff, nxt_ptr;
  logic [1:0]  byte_ff, nxt_byte;
  logic        rnw_ff, nxt_rnw;
  logic [15:0] tx_ff, nxt_tx;
  logic [7:0]  wr_hi_ff, nxt_wr_hi;
  logic        sda_q, nxt_sda;
  logic        oe_q, nxt_oe;
  logic [15:0] conv_ff, nxt_conv;
  logic [15:0] stat_setup_ff, nxt_stat_setup;
  logic [15:0] seq_ff, nxt_seq;
  logic [15:0] timer_ff, nxt_timer;
  logic        chan_ff, nxt_chan;
  logic [27:0] res0_ff, nxt_res0, res1_ff, nxt_res1;
  logic        ready_ff, nxt_ready;
  logic        irq_ff, nxt_irq;
  cks_wr_s     wr;
  logic [15:0] rf_data;
  logic        rf_hit;

  function automatic logic [6:0] own_addr(input logic sel);
    own_addr = sel ? `CKS_BUS_ADDR_HIGH : `CKS_BUS_ADDR_LOW;
  endfunction : own_addr

  wire scl_rise = bus_in.scl && !pins_d_ff[1];
  wire scl_fall = !bus_in.scl && pins_d_ff[1];
  wire start_c  = pins_d_ff[1] && bus_in.scl && pins_d_ff[0] && !bus_in.sda;
  wire stop_c   = pins_d_ff[1] && bus_in.scl && !pins_d_ff[0] && bus_in.sda;

  cks_regfile u_regfile (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .wr         (wr),
    .rd_addr    (ptr_ff),
    .rd_data_ff (rf_data),
    .rd_hit_ff  (rf_hit)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode sequence
  always_comb begin
    nxt_mode = mode_q;
    if (shutdown) begin
      nxt_mode = CKS_SHUTDOWN;
    end else if (mode_q == CKS_SHUTDOWN) begin
      nxt_mode = CKS_SLEEP;
    end else if (conv_ff[`CKS_SLEEP_BIT]) begin
      nxt_mode = CKS_SLEEP;
    end else begin
      nxt_mode = CKS_NORMAL;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-wire slave: pointer write, then 16-bit words msb first
  always_comb begin
    nxt_pins_d = {bus_in.scl, bus_in.sda};
    nxt_bus    = bus_ff;
    nxt_bit    = bit_ff;
    nxt_shift  = shift_ff;
    nxt_ptr    = ptr_ff;
    nxt_byte   = byte_ff;
    nxt_rnw    = rnw_ff;
    nxt_tx     = tx_ff;
    nxt_wr_hi  = wr_hi_ff;
    nxt_sda    = sda_q;
    nxt_oe     = oe_q;
    wr         = '{we: 1'b0, addr: ptr_ff, wdata: {wr_hi_ff, shift_ff}};
    if (mode_q == CKS_SHUTDOWN || stop_c) begin
      nxt_bus = CKS_BUS_IDLE;
      nxt_oe  = 1'b0;
    end else if (start_c) begin
      nxt_bus  = CKS_BUS_ADDR;
      nxt_bit  = 4'h0;
      nxt_byte = 2'b00;
      nxt_oe   = 1'b0;
    end else begin
      case (bus_ff)
        CKS_BUS_ADDR, CKS_BUS_RX: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], bus_in.sda};
            nxt_bit   = bit_ff + 4'h1;
          end
          if (scl_fall && bit_ff == 4'h8) begin
            nxt_bit = 4'h0;
            if (bus_ff == CKS_BUS_ADDR) begin
              nxt_rnw = shift_ff[0];
              if (shift_ff[7:1] == own_addr(addr_sel)) begin
                nxt_bus = CKS_BUS_ACK;
                nxt_oe  = 1'b1;
                nxt_sda = 1'b0;
              end else begin
                nxt_bus = CKS_BUS_SKIP;
              end
            end else begin
              nxt_bus = CKS_BUS_ACK;
              nxt_oe  = 1'b1;
              nxt_sda = 1'b0;
              if (byte_ff == 2'b00) begin
                nxt_ptr = shift_ff;
              end else if (byte_ff == 2'b01) begin
                nxt_wr_hi = shift_ff;
              end else begin
                wr.we   = 1'b1;
                nxt_ptr = ptr_ff + 8'h01;
              end
              nxt_byte = (byte_ff == 2'b10) ? 2'b01 : byte_ff + 2'b01;
            end
          end
        end
        CKS_BUS_ACK: begin
          if (scl_fall) begin
            if (rnw_ff) begin
              // open drain: pull low only for zero bits
              nxt_bus = CKS_BUS_TX;
              nxt_tx  = {tx_ff[14:0], 1'b0};
              nxt_oe  = !tx_ff[15];
              nxt_sda = 1'b0;
            end else begin
              nxt_bus = CKS_BUS_RX;
              nxt_oe  = 1'b0;
            end
          end else if (rnw_ff && byte_ff == 2'b00 && bit_ff == 4'h0) begin
            nxt_tx  = rf_hit ? rf_data : res_word(ptr_ff);
            nxt_bit = 4'h1;
          end
        end
        CKS_BUS_TX: begin
          if (scl_fall) begin
            nxt_bit = bit_ff + 4'h1;
            if (bit_ff == 4'h8 || bit_ff == 4'h0) begin
              nxt_bus = CKS_BUS_RACK;
              nxt_oe  = 1'b0;
              nxt_bit = 4'h0;
            end else begin
              nxt_oe  = !tx_ff[15];
              nxt_tx  = {tx_ff[14:0], 1'b0};
            end
          end
        end
        CKS_BUS_RACK: begin
          if (scl_rise && bus_in.sda) begin
            nxt_bus = CKS_BUS_SKIP;
          end else if (scl_fall) begin
            nxt_bus  = CKS_BUS_TX;
            nxt_oe   = !tx_ff[15];
            nxt_byte = byte_ff + 2'b01;
            nxt_sda  = 1'b0;
            nxt_tx   = {tx_ff[14:0], 1'b0};
            nxt_bit  = 4'h1;
          end
        end
        default: begin
          nxt_oe = 1'b0;
        end
      endcase
    end
  end

  function automatic logic [15:0] res_word(input logic [7:0] a);
    if (a == `CKS_REG_RES0_HIGH) begin
      res_word = {4'h0, res0_ff[27:16]};
    end else if (a == `CKS_REG_RES0_LOW) begin
      res_word = res0_ff[15:0];
    end else if (a == `CKS_REG_RES1_HIGH) begin
      res_word = {4'h0, res1_ff[27:16]};
    end else if (a == `CKS_REG_RES1_LOW) begin
      res_word = res1_ff[15:0];
    end else if (a == `CKS_REG_STATUS) begin
      res_word = {12'h000, ready_ff, 1'b0, mode_q};
    end else if (a == `CKS_REG_CONV_SETUP) begin
      res_word = conv_ff;
    end else begin
      res_word = `CKS_WORD_ZERO;
    end
  endfunction : res_word

  ////////////////////////////////////////////////////////////////////////////
  // shadow copies that steer conversions, and result update
  always_comb begin
    nxt_conv       = conv_ff;
    nxt_stat_setup = stat_setup_ff;
    nxt_seq        = seq_ff;
    if (wr.we && wr.addr == `CKS_REG_CONV_SETUP) begin
      nxt_conv = wr.wdata;
    end
    if (wr.we && wr.addr == `CKS_REG_STAT_SETUP) begin
      nxt_stat_setup = wr.wdata;
    end
    if (wr.we && wr.addr == `CKS_REG_SEQ_SETUP) begin
      nxt_seq = wr.wdata;
    end
    nxt_timer = timer_ff;
    nxt_chan  = chan_ff;
    nxt_res0  = res0_ff;
    nxt_res1  = res1_ff;
    nxt_ready = ready_ff;
    if (mode_q != CKS_NORMAL) begin
      nxt_timer = 16'h0000;
      nxt_chan  = 1'b0;
    end else if (timer_ff == 16'(`CKS_CONV_CYCLES - 1)) begin
      nxt_timer = 16'h0000;
      if (chan_ff) begin
        nxt_res1 = chan1_count;
      end else begin
        nxt_res0 = chan0_count;
      end
      nxt_chan  = seq_ff[`CKS_SEQ_BOTH_BIT] ? !chan_ff : 1'b0;
      nxt_ready = 1'b1;
    end else begin
      nxt_timer = timer_ff + 16'h0001;
    end
    if (bus_ff == CKS_BUS_ACK && rnw_ff && byte_ff == 2'b00 && bit_ff == 4'h0
        && ptr_ff == `CKS_REG_STATUS && !nxt_ready) begin
      nxt_ready = 1'b0;
    end else if (bus_ff == CKS_BUS_ACK && rnw_ff && byte_ff == 2'b00 && bit_ff == 4'h0
        && ptr_ff == `CKS_REG_STATUS && timer_ff != 16'(`CKS_CONV_CYCLES - 1)) begin
      nxt_ready = 1'b0;
    end
    nxt_irq = !(ready_ff && stat_setup_ff[`CKS_STAT_IRQ_EN_BIT]);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q        <= CKS_SLEEP;
      mode_ff       <= CKS_SLEEP;
      osc_enable_ff <= 1'b0;
      bus_ff        <= CKS_BUS_IDLE;
      pins_d_ff     <= 2'b11;
      bit_ff        <= 4'h0;
      shift_ff      <= 8'h00;
      ptr_ff        <= 8'h00;
      byte_ff       <= 2'b00;
      rnw_ff        <= 1'b0;
      tx_ff         <= `CKS_WORD_ZERO;
      wr_hi_ff      <= 8'h00;
      sda_q         <= 1'b1;
      oe_q          <= 1'b0;
      sda_out_ff    <= 1'b1;
      sda_oe_ff     <= 1'b0;
      conv_ff       <= `CKS_CONV_SETUP_RST;
      stat_setup_ff <= `CKS_WORD_ZERO;
      seq_ff        <= `CKS_WORD_ZERO;
      timer_ff      <= 16'h0000;
      chan_ff       <= 1'b0;
      res0_ff       <= 28'h000_0000;
      res1_ff       <= 28'h000_0000;
      ready_ff      <= 1'b0;
      irq_ff        <= 1'b1;
    end else begin
      mode_q        <= nxt_mode;
      mode_ff       <= nxt_mode;
      osc_enable_ff <= !shutdown;
      bus_ff        <= nxt_bus;
      pins_d_ff     <= nxt_pins_d;
      bit_ff        <= nxt_bit;
      shift_ff      <= nxt_shift;
      ptr_ff        <= nxt_ptr;
      byte_ff       <= nxt_byte;
      rnw_ff        <= nxt_rnw;
      tx_ff         <= nxt_tx;
      wr_hi_ff      <= nxt_wr_hi;
      sda_q         <= nxt_sda;
      oe_q          <= nxt_oe;
      sda_out_ff    <= nxt_sda;
      sda_oe_ff     <= nxt_oe;
      conv_ff       <= nxt_conv;
      stat_setup_ff <= nxt_stat_setup;
      seq_ff        <= nxt_seq;
      timer_ff      <= nxt_timer;
      chan_ff       <= nxt_chan;
      res0_ff       <= nxt_res0;
      res1_ff       <= nxt_res1;
      ready_ff      <= nxt_ready;
      irq_ff        <= nxt_irq;
    end
  end

  assign result_ready_irq_n = irq_ff;
endmodule : cks_sequencer

// File: cks_cfg.svh
// register offsets, field positions, reset values and timing counts of the kick sensor sequencer
`ifndef CKS_CFG_SVH
`define CKS_CFG_SVH
`define CKS_BUS_ADDR_LOW      7'h2A
`define CKS_BUS_ADDR_HIGH     7'h2B
`define CKS_REG_RES0_HIGH     8'h00
`define CKS_REG_RES0_LOW      8'h01
`define CKS_REG_RES1_HIGH     8'h02
`define CKS_REG_RES1_LOW      8'h03
`define CKS_REG_REF_CNT0      8'h08
`define CKS_REG_REF_CNT1      8'h09
`define CKS_REG_SETTLE0       8'h10
`define CKS_REG_SETTLE1       8'h11
`define CKS_REG_DIV0          8'h14
`define CKS_REG_DIV1          8'h15
`define CKS_REG_STATUS        8'h18
`define CKS_REG_STAT_SETUP    8'h19
`define CKS_REG_CONV_SETUP    8'h1A
`define CKS_REG_SEQ_SETUP     8'h1B
`define CKS_REG_DRIVE0        8'h1E
`define CKS_REG_DRIVE1        8'h1F
`define CKS_SLEEP_BIT         13
`define CKS_SEQ_BOTH_BIT      15
`define CKS_STAT_IRQ_EN_BIT   0
`define CKS_STAT_READY_BIT    3
`define CKS_CONV_SETUP_RST    16'h2801
`define CKS_REF_CNT_RST       16'h0080
`define CKS_SETTLE_RST        16'h0000
`define CKS_WORD_ZERO         16'h0000
`define CKS_CONV_TIME_NS      1000
`define CKS_CLK_NS            25
`define CKS_CONV_CYCLES       ((`CKS_CONV_TIME_NS + `CKS_CLK_NS - 1) / `CKS_CLK_NS)
`endif

// File: cks_pkg.sv
// types of the kick sensor sequencer
package cks_pkg;
  typedef enum logic [1:0] {
    CKS_SHUTDOWN = 2'b00,
    CKS_SLEEP    = 2'b01,
    CKS_NORMAL   = 2'b11
  } cks_mode_e;
  typedef enum logic [2:0] {
    CKS_BUS_IDLE = 3'b000,
    CKS_BUS_ADDR = 3'b001,
    CKS_BUS_ACK  = 3'b011,
    CKS_BUS_RX   = 3'b010,
    CKS_BUS_TX   = 3'b110,
    CKS_BUS_RACK = 3'b111,
    CKS_BUS_SKIP = 3'b101
  } cks_bus_e;
  typedef struct packed {
    logic        scl;
    logic        sda;
  } cks_pins_s;
  typedef struct packed {
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } cks_wr_s;
endpackage : cks_pkg

// File: cks_regfile.sv
// configuration register store with registered read data
`timescale 1ns/1ps
`include "cks_cfg.svh"
module cks_regfile
  import cks_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // write port
  input  wire cks_wr_s     wr,
  // read port
  input  wire logic [7:0]  rd_addr,
  output logic      [15:0] rd_data_ff,
  output logic             rd_hit_ff
);
  localparam int NREG = 11;
  localparam logic [7:0] ADDRS [NREG] = '{`CKS_REG_REF_CNT0, `CKS_REG_REF_CNT1, `CKS_REG_SETTLE0,
    `CKS_REG_SETTLE1, `CKS_REG_DIV0, `CKS_REG_DIV1, `CKS_REG_STAT_SETUP, `CKS_REG_CONV_SETUP,
    `CKS_REG_SEQ_SETUP, `CKS_REG_DRIVE0, `CKS_REG_DRIVE1};
  logic [15:0] mem_ff [NREG];
  logic [15:0] nxt_rd_data;
  logic        nxt_rd_hit;

  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      // power-up value of this word
      localparam logic [15:0] RST_VAL = (ADDRS[g] == `CKS_REG_CONV_SETUP) ? `CKS_CONV_SETUP_RST :
        (ADDRS[g] == `CKS_REG_REF_CNT0 || ADDRS[g] == `CKS_REG_REF_CNT1) ? `CKS_REF_CNT_RST :
        (ADDRS[g] == `CKS_REG_SETTLE0 || ADDRS[g] == `CKS_REG_SETTLE1) ? `CKS_SETTLE_RST : `CKS_WORD_ZERO;
      logic [15:0] nxt_word;
      always_comb begin
        nxt_word = mem_ff[g];
        if (wr.we && wr.addr == ADDRS[g]) begin
          nxt_word = wr.wdata;
        end
      end
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          mem_ff[g] <= RST_VAL;
        end else begin
          mem_ff[g] <= nxt_word;
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_rd_data = `CKS_WORD_ZERO;
    nxt_rd_hit  = 1'b0;
    for (int i = 0; i < NREG; i++) begin
      if (rd_addr == ADDRS[i]) begin
        nxt_rd_data = mem_ff[i];
        nxt_rd_hit  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_ff <= `CKS_WORD_ZERO;
      rd_hit_ff  <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_hit_ff  <= nxt_rd_hit;
    end
  end
endmodule : cks_regfile

// File: cks_sequencer_chk.sv
// port checks of the kick sensor converter
`timescale 1ns/1ps
module cks_sequencer_chk
  import cks_pkg::*;
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // watched pins
  input wire logic       shutdown,
  input wire cks_pins_s  bus_in,
  input wire logic       sda_out_ff,
  input wire logic       sda_oe_ff,
  input wire logic       osc_enable_ff,
  input wire logic [1:0] mode_ff
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sequence s_wake;
    $fell(shutdown);
  endsequence
  sequence s_held_off;
    (mode_ff == CKS_SHUTDOWN) [*2];
  endsequence
  property p_reset_sleep;
    $fell(rst) |-> mode_ff == CKS_SLEEP;
  endproperty
  property p_shut_enter;
    !rst && shutdown |=> mode_ff == CKS_SHUTDOWN;
  endproperty
  property p_wake_sleep;
    s_wake |=> mode_ff == CKS_SLEEP;
  endproperty
  property p_osc_follow;
    !$past(rst) |-> osc_enable_ff == !$past(shutdown);
  endproperty
  property p_normal_src;
    $rose(mode_ff == CKS_NORMAL) |-> $past(mode_ff) == CKS_SLEEP;
  endproperty
  property p_bus_quiet;
    s_held_off |-> !sda_oe_ff;
  endproperty
  property p_ack_scl_low;
    $rose(sda_oe_ff) |-> !bus_in.scl;
  endproperty
  property p_drive_low;
    sda_oe_ff |-> !sda_out_ff;
  endproperty
  a_reset_sleep: assert property (p_reset_sleep)
    else $error("mode not sleep after reset");
  a_shut_enter: assert property (p_shut_enter)
    else $error("shutdown pin not obeyed");
  a_wake_sleep: assert property (p_wake_sleep)
    else $error("no sleep after shutdown release");
  a_osc_follow: assert property (p_osc_follow)
    else $error("oscillator enable not inverse of shutdown");
  a_normal_src: assert property (p_normal_src)
    else $error("normal entered not from sleep");
  a_bus_quiet: assert property (p_bus_quiet)
    else $error("bus driven in shutdown");
  a_ack_scl_low: assert property (p_ack_scl_low)
    else $error("data line taken while clock high");
  a_drive_low: assert property (p_drive_low)
    else $error("data line driven high");
endmodule : cks_sequencer_chk

// File: cks_host.sv
// bus master model standing in for the host controller
`timescale 1ns/1ps
module cks_host
  import cks_pkg::*;
(
  // clock
  input  wire logic clk_sys,
  // device pull on the data line
  input  wire logic dev_pull,
  // resolved bus levels
  output cks_pins_s pins
);
  logic scl_q = 1'b1;
  logic low_q = 1'b0;
  // open drain with pull-up
  assign pins = '{scl: scl_q, sda: ~(low_q | dev_pull)};
  ////////////////////////////////////////////////////////////
  task automatic wt();
    repeat (3) @(posedge clk_sys);
  endtask : wt
  task automatic bit_io(input logic b, output logic r);
    low_q <= ~b;
    wt();
    scl_q <= 1'b1;
    wt();
    r = pins.sda;
    scl_q <= 1'b0;
    wt();
  endtask : bit_io
  // also serves as repeated start
  task automatic start();
    @(posedge clk_sys);
    low_q <= 1'b0;
    wt();
    scl_q <= 1'b1;
    wt();
    low_q <= 1'b1;
    wt();
    scl_q <= 1'b0;
    wt();
  endtask : start
  task automatic stop();
    low_q <= 1'b1;
    wt();
    scl_q <= 1'b1;
    wt();
    low_q <= 1'b0;
    wt();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m, a);
  endtask : xfer
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [15:0] v, output logic ok);
    logic [7:0] q;
    logic [3:0] k;
    start();
    xfer({a, 1'b0}, 1'b1, q, k[3]);
    xfer(r, 1'b1, q, k[2]);
    xfer(v[15:8], 1'b1, q, k[1]);
    xfer(v[7:0], 1'b1, q, k[0]);
    stop();
    ok = (k === 4'h0);
  endtask : wr
  // one register per read transaction
  task automatic rd(input logic [6:0] a, input logic [7:0] r, output logic [15:0] v, output logic ok);
    logic [7:0] q;
    logic [2:0] k;
    logic       n;
    start();
    xfer({a, 1'b0}, 1'b1, q, k[2]);
    xfer(r, 1'b1, q, k[1]);
    start();
    xfer({a, 1'b1}, 1'b1, q, k[0]);
    xfer(8'hFF, 1'b0, v[15:8], n);
    xfer(8'hFF, 1'b1, v[7:0], n);
    stop();
    ok = (k === 3'h0);
  endtask : rd
endmodule : cks_host

// File: test_capacitive_kick_sensor_sequencer.sv
// self-checking bench of the kick sensor converter
`timescale 1ns/1ps
`include "cks_cfg.svh"
module test_capacitive_kick_sensor_sequencer
  import cks_pkg::*;
;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        shutdown = 1'b1;
  logic        addr_sel = 1'b0;
  logic [27:0] chan0_count = '0;
  logic [27:0] chan1_count = '0;
  cks_pins_s   bus_in;
  logic        sda_oe_ff, sda_out, irq_n, osc_en, ok;
  logic        kick_open = 1'b0;
  logic [27:0] old1;
  logic [1:0]  mode;
  logic [6:0]  dev;
  logic [15:0] v;
  logic [15:0] wv [11];
  logic [7:0]  regs [11] = '{`CKS_REG_REF_CNT0, `CKS_REG_REF_CNT1, `CKS_REG_SETTLE0, `CKS_REG_SETTLE1,
    `CKS_REG_DIV0, `CKS_REG_DIV1, `CKS_REG_STAT_SETUP, `CKS_REG_CONV_SETUP, `CKS_REG_SEQ_SETUP,
    `CKS_REG_DRIVE0, `CKS_REG_DRIVE1};
  int          err_count = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          seed = 32'h7687;
  always #12.5 clk_sys = ~clk_sys;
  cks_sequencer u_cks_sequencer (
    .clk_sys(clk_sys),
    .rst(rst),
    .shutdown(shutdown),
    .addr_sel(addr_sel),
    .bus_in(bus_in),
    .sda_out_ff(sda_out),
    .sda_oe_ff(sda_oe_ff),
    .chan0_count(chan0_count),
    .chan1_count(chan1_count),
    .result_ready_irq_n(irq_n),
    .osc_enable_ff(osc_en),
    .mode_ff(mode)
  );
  cks_host u_cks_host (
    .clk_sys(clk_sys),
    .dev_pull(sda_oe_ff & ~sda_out),
    .pins(bus_in)
  );
  ////////////////////////////////////////////////////////////
  function automatic logic [15:0] hi_word(input logic [27:0] c);
    return {4'h0, c[27:16]};
  endfunction : hi_word
  function automatic logic [15:0] stat_word(input logic rdy, input logic [1:0] md);
    return {12'h000, rdy, 1'b0, md};
  endfunction : stat_word
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic note(input logic bad, input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (bad) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : note
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    note(g !== e, g, e);
  endtask : chk_word
  task automatic chk_pin(input logic [1:0] g, input logic [1:0] e);
    note(g !== e, {14'h0, g}, {14'h0, e});
  endtask : chk_pin
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic wreg(input logic [7:0] r, input logic [15:0] d);
    u_cks_host.wr(dev, r, d, ok);
  endtask : wreg
  task automatic rreg(input logic [7:0] r, input logic [15:0] e);
    u_cks_host.rd(dev, r, v, ok);
    chk_word(v, e);
  endtask : rreg
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    dev = `CKS_BUS_ADDR_LOW;
    // key fob absent: converter held off, bus deaf
    tick(4);
    chk_pin(mode, CKS_SHUTDOWN);
    chk_pin({1'b0, osc_en}, 2'b00);
    u_cks_host.wr(dev, `CKS_REG_REF_CNT0, 16'h1234, ok);
    chk_pin({1'b0, ok}, 2'b00);
    @(posedge clk_sys);
    shutdown <= 1'b0;
    tick(2);
    chk_pin(mode, CKS_SLEEP);
    chk_pin({1'b0, osc_en}, 2'b01);
    rreg(`CKS_REG_CONV_SETUP, `CKS_CONV_SETUP_RST);
    // both select levels, wrong address refused
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      addr_sel <= s[0];
      u_cks_host.wr(s[0] ? `CKS_BUS_ADDR_LOW : `CKS_BUS_ADDR_HIGH, `CKS_REG_REF_CNT0, 16'h4321, ok);
      chk_pin({1'b0, ok}, 2'b00);
      dev = s[0] ? `CKS_BUS_ADDR_HIGH : `CKS_BUS_ADDR_LOW;
      rreg(`CKS_REG_REF_CNT0, `CKS_REF_CNT_RST);
    end
    for (int i = 0; i < 11; i++) begin
      wv[i] = 16'($random(seed));
    end
    wv[6][`CKS_STAT_IRQ_EN_BIT] = 1'b1;
    wv[7][`CKS_SLEEP_BIT] = 1'b1;
    wv[8][`CKS_SEQ_BOTH_BIT] = 1'b1;
    for (int i = 0; i < 11; i++) begin
      wreg(regs[i], wv[i]);
    end
    for (int i = 0; i < 11; i++) begin
      rreg(regs[i], wv[i]);
    end
    rreg(8'h05, `CKS_WORD_ZERO);
    tick(100);
    chk_pin(mode, CKS_SLEEP);
    chk_pin({1'b0, irq_n}, 2'b01);
    wreg(`CKS_REG_CONV_SETUP, wv[7] & 16'hDFFF);
    chk_pin(mode, CKS_NORMAL);
    for (int n = 0; n < 3; n++) begin
      @(posedge clk_sys);
      chan0_count <= 28'($random(seed));
      chan1_count <= 28'($random(seed));
      tick(100);
      chk_pin({1'b0, irq_n}, 2'b00);
      rreg(`CKS_REG_STATUS, stat_word(1'b1, CKS_NORMAL));
      rreg(`CKS_REG_RES0_HIGH, hi_word(chan0_count));
      rreg(`CKS_REG_RES0_LOW, chan0_count[15:0]);
      rreg(`CKS_REG_RES1_HIGH, hi_word(chan1_count));
      rreg(`CKS_REG_RES1_LOW, chan1_count[15:0]);
      kick_open <= !shutdown && v[0];
    end
    // settings changed only while asleep, interrupt masked, channel 1 left out
    wreg(`CKS_REG_CONV_SETUP, wv[7]);
    chk_pin(mode, CKS_SLEEP);
    wreg(`CKS_REG_STAT_SETUP, wv[6] & 16'hFFFE);
    chk_pin({1'b0, irq_n}, 2'b01);
    rreg(`CKS_REG_STAT_SETUP, wv[6] & 16'hFFFE);
    wreg(`CKS_REG_SEQ_SETUP, wv[8] & 16'h7FFF);
    wreg(`CKS_REG_CONV_SETUP, wv[7] & 16'hDFFF);
    chk_pin(mode, CKS_NORMAL);
    old1 = chan1_count;
    @(posedge clk_sys);
    chan0_count <= 28'($random(seed));
    chan1_count <= 28'($random(seed));
    tick(100);
    rreg(`CKS_REG_RES0_LOW, chan0_count[15:0]);
    rreg(`CKS_REG_RES1_LOW, old1[15:0]);
    // key fob lost
    @(posedge clk_sys);
    kick_open <= 1'b0;
    shutdown <= 1'b1;
    tick(3);
    chk_pin(mode, CKS_SHUTDOWN);
    chk_pin({1'b0, osc_en}, 2'b00);
    chk_pin({1'b0, kick_open & shutdown}, 2'b00);
    stop_test();
  end
endmodule : test_capacitive_kick_sensor_sequencer

bind cks_sequencer cks_sequencer_chk u_cks_sequencer_chk (
  .clk_sys(clk_sys),
  .rst(rst),
  .shutdown(shutdown),
  .bus_in(bus_in),
  .sda_out_ff(sda_out_ff),
  .sda_oe_ff(sda_oe_ff),
  .osc_enable_ff(osc_enable_ff),
  .mode_ff(mode_ff)
);
